/* File: core/irq_tb_ctrl.sv */
// interrupt controller with time base dividers and apb registers
// Contract
// - comparator, converter, time base and group source events set their flags regardless of enables
// - a flag with its enable clear stays set, no vector
// - global enable low blocks every interrupt to the core
// - taking an interrupt pushes return pc, loads source vector
// - return from interrupt pops the saved pc
// - servicing any interrupt clears global enable
// - requests during blocking still set and hold flags
// - full stack blocks acknowledge until the pointer drops
// - any flag rising wakes from sleep; preset flag suppresses it
// - external flags set on the selected pin transition
// - edge field: 00 off, 01 rise, 10 fall, 11 both
// - pin acts only if enabled, muxed to interrupt, and input
// - servicing an external interrupt clears its flag and global
// - pull-high stays in effect on interrupt pins
// - comparator flag sets on output change, clears on service
// - three group interrupts aggregate timer, voltage, eeprom flags
// - a group flag sets when any contained flag with its enable set rises
// - service clears only the group flag, sources by software
// - converter flag sets on conversion end, clears on service
// - time base flag sets on overflow, clears on service
// - two prescaler selectors: system, system/4 or subclock
// - prescaler field: 00 system, 01 system/4, 1x subclock
// - period field selects 2^8..2^15 prescaled clocks
// - divider runs only while its control msb is set
`timescale 1ns/1ps
module irq_tb_ctrl
    import irq_tb_pkg::*;
#(
    parameter int PC_W    = 16,
    parameter int STACK_D = 8
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              clk_en_in,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins and sources
    input  wire logic [2:0]        ext_irq_pins_in,
    input  wire logic [2:0]        pin_mux_irq_in,
    input  wire logic [2:0]        pin_dir_input_in,
    input  wire logic [2:0]        pin_pull_high_in,
    output logic      [2:0]        pin_pull_high_out,
    input  wire logic              cmp_output_in,
    input  wire logic              conv_done_in,
    input  wire logic [7:0]        grp0_event_in,
    input  wire logic [7:0]        grp1_event_in,
    input  wire logic [1:0]        grp2_event_in,
    input  wire logic              subclock_tick_in,
    // core side
    input  wire logic [PC_W-1:0]   next_pc_in,
    input  wire logic              ret_irq_in,
    input  wire logic              sleep_in,
    input  wire logic              stack_pop_in,
    output logic                   irq_take_out,
    output logic      [PC_W-1:0]   pc_load_out,
    output logic                   pc_load_valid_out,
    output logic                   wake_out
);
    localparam int SP_W = $clog2(STACK_D + 1);

    // registers
    logic [7:0] ctrl0_q, ctrl1_q, ctrl2_q, ctrl3_q;
    logic [7:0] grp0_q, grp1_q, grp2_q, edge_q;
    logic [7:0] psc0_q, psc1_q, per0_q, per1_q;
    logic [PC_W-1:0] stack_q [STACK_D];
    logic [SP_W-1:0] sp_q;
    logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic       cmp_s1_q, cmp_s2_q, cmp_s3_q;
    logic       sub_s1_q, sub_s2_q, sub_s3_q;
    logic [1:0] div4_q;
    logic [15:0] per_cnt_q [2];
    logic [1:0] per_ovf;
    logic [NUM_SRC-1:0] flag, en, pend, svc;
    logic [2:0] ext_hit, grp_rise;
    logic       take, stack_full, global_en;
    logic [3:0] sel;
    logic [NUM_SRC-1:0] flag_prev_q;
    logic [9:0] src_flag, src_prev_q;
    logic       wr, rd;

    assign pin_pull_high_out = pin_pull_high_in;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // pin and source synchronisers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            cmp_s3_q <= 1'b0;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else if (clk_en_in) begin
            pin_s1_q <= ext_irq_pins_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            cmp_s1_q <= cmp_output_in;
            cmp_s2_q <= cmp_s1_q;
            cmp_s3_q <= cmp_s2_q;
            sub_s1_q <= subclock_tick_in;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    // edge detection per external pin
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ext
            logic rise, fall, active;
            logic [1:0] mode;
            assign mode = edge_q[2*gi +: 2];
            assign rise = pin_s2_q[gi] && !pin_s3_q[gi];
            assign fall = !pin_s2_q[gi] && pin_s3_q[gi];
            assign active = en[SRC_EXT0+gi] && pin_mux_irq_in[gi]
                            && pin_dir_input_in[gi];
            assign ext_hit[gi] = active &&
                ((rise && (mode == EDGE_RISE || mode == EDGE_BOTH)) ||
                 (fall && (mode == EDGE_FALL || mode == EDGE_BOTH)));
        end
    endgenerate

    // flag and enable views
    assign global_en = ctrl0_q[0];
    assign flag = {ctrl2_q[4], ctrl1_q[7], ctrl1_q[6], ctrl1_q[5],
                   ctrl1_q[4], ctrl0_q[6], ctrl0_q[5], ctrl3_q[5],
                   ctrl2_q[5], ctrl0_q[4]};
    assign en   = {ctrl2_q[0], ctrl1_q[3], ctrl1_q[2], ctrl1_q[1],
                   ctrl1_q[0], ctrl0_q[3], ctrl0_q[2], ctrl3_q[1],
                   ctrl2_q[1], ctrl0_q[1]};
    assign pend = flag & en;
    assign stack_full = (sp_q == SP_W'(STACK_D));
    assign take = global_en && (|pend) && !stack_full
                  && clk_en_in;

    // fixed priority pick
    always_comb begin
        sel = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel = 4'(i);
            end
        end
    end
    assign svc = take ? (NUM_SRC'(1) << sel) : '0;

    // group flags: contained flag and enable pairs
    generate
        for (gi = 0; gi < 3; gi++) begin : g_grp
            logic [7:0] gr;
            logic [3:0] fl, fe;
            logic [3:0] fl_prev_q;
            assign gr = (gi == 0) ? grp0_q : (gi == 1) ? grp1_q : grp2_q;
            assign fl = gr[7:4];
            assign fe = gr[3:0];
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    fl_prev_q <= 4'h0;
                end else if (clk_en_in) begin
                    fl_prev_q <= fl;
                end
            end
            assign grp_rise[gi] = |(fl & fe & ~fl_prev_q);
        end
    endgenerate

    // prescaler ticks and time base dividers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            div4_q <= 2'h0;
        end else if (clk_en_in) begin
            div4_q <= div4_q + 2'h1;
        end
    end
    generate
        for (gi = 0; gi < 2; gi++) begin : g_per
            logic [1:0] src;
            logic [7:0] pc;
            logic       tick;
            logic [15:0] lim;
            assign src = (gi == 0) ? psc0_q[1:0] : psc1_q[1:0];
            assign pc  = (gi == 0) ? per0_q : per1_q;
            always_comb begin
                unique case (src)
                    PSC_SYS:  tick = 1'b1;
                    PSC_SYS4: tick = (div4_q == 2'h3);
                    default:  tick = sub_s2_q && !sub_s3_q;
                endcase
            end
            assign lim = 16'((32'h1 << (PER_MIN_LOG2 + pc[2:0])) - 1);
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    per_cnt_q[gi] <= 16'h0000;
                end else if (clk_en_in) begin
                    if (!pc[PER_RUN_BIT]) begin
                        per_cnt_q[gi] <= 16'h0000;
                    end else if (tick) begin
                        per_cnt_q[gi] <= (per_cnt_q[gi] >= lim) ?
                            16'h0000 : per_cnt_q[gi] + 16'h1;
                    end
                end
            end
            assign per_ovf[gi] = pc[PER_RUN_BIT] && tick
                                 && (per_cnt_q[gi] >= lim);
        end
    endgenerate

    // control registers: hardware set wins over clear
    function automatic logic [7:0] upd(input logic [7:0] cur,
                                       input logic       we,
                                       input logic [7:0] wd,
                                       input logic [7:0] set,
                                       input logic [7:0] clr,
                                       input logic [7:0] mask);
        logic [7:0] v;
        v = we ? wd : cur;
        return ((v & ~clr) | set) & mask;
    endfunction

    logic [31:0] wd;
    assign wd = pwdata;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl0_q <= RST_BYTE;
            ctrl1_q <= RST_BYTE;
            ctrl2_q <= RST_BYTE;
            ctrl3_q <= RST_BYTE;
        end else if (clk_en_in) begin
            // comparator, converter and time base events set flags whatever the enables
            ctrl0_q <= upd(ctrl0_q, wr && paddr == OFF_CTRL0, wd[7:0],
                {1'b0, grp_rise[0], cmp_s2_q ^ cmp_s3_q, ext_hit[0],
                 4'h0},
                {1'b0, svc[SRC_GRP0], svc[SRC_CMP], svc[SRC_EXT0],
                 3'h0, take}, 8'h7f);
            ctrl1_q <= upd(ctrl1_q, wr && paddr == OFF_CTRL1, wd[7:0],
                {per_ovf[0], conv_done_in, grp_rise[2], grp_rise[1],
                 4'h0},
                {svc[SRC_PER0], svc[SRC_CONV], svc[SRC_GRP2],
                 svc[SRC_GRP1], 4'h0}, 8'hff);
            ctrl2_q <= upd(ctrl2_q, wr && paddr == OFF_CTRL2, wd[7:0],
                {2'h0, ext_hit[1], per_ovf[1], 4'h0},
                {2'h0, svc[SRC_EXT1], svc[SRC_PER1], 4'h0}, 8'hff);
            ctrl3_q <= upd(ctrl3_q, wr && paddr == OFF_CTRL3, wd[7:0],
                {2'h0, ext_hit[2], 5'h0},
                {2'h0, svc[SRC_EXT2], 5'h0}, 8'h33);
        end
    end

    // group source registers, cleared by software only
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            grp0_q <= RST_BYTE;
            grp1_q <= RST_BYTE;
            grp2_q <= RST_BYTE;
        end else if (clk_en_in) begin
            grp0_q <= upd(grp0_q, wr && paddr == OFF_GROUP0, wd[7:0],
                {grp0_event_in[3:0], 4'h0}, 8'h00, 8'hff);
            grp1_q <= upd(grp1_q, wr && paddr == OFF_GROUP1, wd[7:0],
                {grp1_event_in[3:0], 4'h0}, 8'h00, 8'hff);
            grp2_q <= upd(grp2_q, wr && paddr == OFF_GROUP2, wd[7:0],
                {2'h0, grp2_event_in, 4'h0}, 8'h00, 8'h33);
        end
    end

    // configuration registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            edge_q <= RST_BYTE;
            psc0_q <= RST_BYTE;
            psc1_q <= RST_BYTE;
            per0_q <= RST_BYTE;
            per1_q <= RST_BYTE;
        end else if (clk_en_in && wr) begin
            unique case (paddr)
                OFF_EDGE:    edge_q <= wd[7:0] & 8'h3f;
                OFF_PSC0:    psc0_q <= wd[7:0] & 8'h03;
                OFF_PSC1:    psc1_q <= wd[7:0] & 8'h03;
                OFF_PERIOD0: per0_q <= wd[7:0] & 8'h87;
                OFF_PERIOD1: per1_q <= wd[7:0] & 8'h87;
                default: ;
            endcase
        end
    end

    // return stack
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sp_q <= '0;
        end else if (clk_en_in) begin
            if (take) begin
                stack_q[sp_q[$clog2(STACK_D)-1:0]] <= next_pc_in;
                sp_q <= sp_q + SP_W'(1);
            end else if ((ret_irq_in || stack_pop_in) && sp_q != '0) begin
                sp_q <= sp_q - SP_W'(1);
            end
        end
    end

    // pc load to the core
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc_load_out       <= BOOT_PC;
            pc_load_valid_out <= 1'b0;
            irq_take_out      <= 1'b0;
        end else if (clk_en_in) begin
            irq_take_out      <= take;
            pc_load_valid_out <= take || (ret_irq_in && sp_q != '0);
            if (take) begin
                pc_load_out <= PC_W'(VEC_BASE + VEC_STEP * 12'(sel));
            end else if (ret_irq_in && sp_q != '0) begin
                pc_load_out <= stack_q[sp_q[$clog2(STACK_D)-1:0] - 1'b1];
            end
        end
    end

    // wake on any flag rise, contained group sources included
    assign src_flag = {grp0_q[7:4], grp1_q[7:4], grp2_q[5:4]};
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flag_prev_q <= '0;
            src_prev_q  <= '0;
            wake_out    <= 1'b0;
        end else if (clk_en_in) begin
            flag_prev_q <= flag;
            src_prev_q  <= src_flag;
            wake_out    <= sleep_in && (|(flag & ~flag_prev_q)
                           || |(src_flag & ~src_prev_q));
        end
    end

    // apb read mux
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en_in && psel && !penable && !pwrite) begin
            unique case (paddr)
                OFF_CTRL0:   prdata <= {24'h0, ctrl0_q};
                OFF_CTRL1:   prdata <= {24'h0, ctrl1_q};
                OFF_CTRL2:   prdata <= {24'h0, ctrl2_q};
                OFF_CTRL3:   prdata <= {24'h0, ctrl3_q};
                OFF_GROUP0:  prdata <= {24'h0, grp0_q};
                OFF_GROUP1:  prdata <= {24'h0, grp1_q};
                OFF_GROUP2:  prdata <= {24'h0, grp2_q};
                OFF_EDGE:    prdata <= {24'h0, edge_q};
                OFF_PSC0:    prdata <= {24'h0, psc0_q};
                OFF_PSC1:    prdata <= {24'h0, psc1_q};
                OFF_PERIOD0: prdata <= {24'h0, per0_q};
                OFF_PERIOD1: prdata <= {24'h0, per1_q};
                OFF_STATUS:  prdata <= 32'(sp_q);
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    chk_global_block: assert property (@(posedge clock_in)
        disable iff (rst_in) !global_en |-> !take)
        else $error("interrupt taken with global enable low");
    chk_take_clears: assert property (@(posedge clock_in)
        disable iff (rst_in) take |=> !global_en || $past(wr))
        else $error("global enable not cleared on service");
    chk_full_block: assert property (@(posedge clock_in)
        disable iff (rst_in) stack_full |-> !take)
        else $error("interrupt taken with full stack");
    chk_vector_load: assert property (@(posedge clock_in)
        disable iff (rst_in) take |=> pc_load_valid_out && irq_take_out)
        else $error("no vector load after take");
    chk_masked_none: assert property (@(posedge clock_in)
        disable iff (rst_in) (pend == '0) |-> !take)
        else $error("take with nothing pending");
    chk_prio_pick: assert property (@(posedge clock_in)
        disable iff (rst_in) take |-> ((pend & (svc - 1'b1)) == '0))
        else $error("lower priority source served first");
    chk_cmp_flag: assert property (@(posedge clock_in)
        disable iff (rst_in) clk_en_in && (cmp_s2_q ^ cmp_s3_q)
        |=> ctrl0_q[5])
        else $error("comparator change lost");
    chk_ext_clear: assert property (@(posedge clock_in)
        disable iff (rst_in) svc[SRC_EXT0] && !ext_hit[0] && !wr
        |=> !ctrl0_q[4])
        else $error("external flag not cleared on service");
    cov_take: cover property (@(posedge clock_in) take);
    cov_ret: cover property (@(posedge clock_in) ret_irq_in && sp_q != '0);
    cov_full: cover property (@(posedge clock_in) stack_full && |pend);
    cov_ovf: cover property (@(posedge clock_in) per_ovf[0]);
endmodule // irq_tb_ctrl

/* File: core/irq_tb_pkg.sv */
// constants for the interrupt and time base controller
package irq_tb_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_CTRL1    = 8'h04;
    localparam logic [7:0] OFF_CTRL2    = 8'h08;
    localparam logic [7:0] OFF_CTRL3    = 8'h0c;
    localparam logic [7:0] OFF_GROUP0   = 8'h10;
    localparam logic [7:0] OFF_GROUP1   = 8'h14;
    localparam logic [7:0] OFF_GROUP2   = 8'h18;
    localparam logic [7:0] OFF_EDGE     = 8'h1c;
    localparam logic [7:0] OFF_PSC0     = 8'h20;
    localparam logic [7:0] OFF_PSC1     = 8'h24;
    localparam logic [7:0] OFF_PERIOD0  = 8'h28;
    localparam logic [7:0] OFF_PERIOD1  = 8'h2c;
    localparam logic [7:0] OFF_STATUS   = 8'h30;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    // source indices, lowest index is lowest vector, highest priority
    localparam int SRC_EXT0  = 0;
    localparam int SRC_EXT1  = 1;
    localparam int SRC_EXT2  = 2;
    localparam int SRC_CMP   = 3;
    localparam int SRC_GRP0  = 4;
    localparam int SRC_GRP1  = 5;
    localparam int SRC_GRP2  = 6;
    localparam int SRC_CONV  = 7;
    localparam int SRC_PER0  = 8;
    localparam int SRC_PER1  = 9;
    localparam int NUM_SRC   = 10;
    localparam logic [11:0] VEC_BASE = 12'h004;
    localparam logic [11:0] VEC_STEP = 12'h004;
    // edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // prescaler source codes
    localparam logic [1:0] PSC_SYS   = 2'h0;
    localparam logic [1:0] PSC_SYS4  = 2'h1;
    localparam int PER_MIN_LOG2      = 8;
    localparam int PER_RUN_BIT       = 7;
    localparam logic [15:0] BOOT_PC  = 16'h0000;
endpackage : irq_tb_pkg

/* File: sim/core_model.sv */
// processor core fetch and stack stand-in
`timescale 1ns/1ps
module core_model
    import irq_tb_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] pc_load_in,
    input  wire logic        pc_valid_in,
    input  wire logic        ret_req_in,
    output logic      [15:0] next_pc_out,
    output logic             ret_irq_out,
    output logic             stack_pop_out
);
    logic [15:0] pc_q;
    // fetch address follows every vector or return load
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc_q <= BOOT_PC;
        end else if (pc_valid_in) begin
            pc_q <= pc_load_in;
        end
    end
    // one-cycle return from interrupt
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ret_irq_out <= 1'b0;
        end else begin
            ret_irq_out <= ret_req_in;
        end
    end
    assign next_pc_out   = pc_q + 16'h0002;
    assign stack_pop_out = 1'b0;
endmodule // core_model

/* File: sim/test_mcu_interrupt_and_timebase_ctrl.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module test_mcu_interrupt_and_timebase_ctrl;
    import irq_tb_pkg::*;
    logic        clock_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic        cmp_in = 0, conv_in = 0, sleep = 0, ret_req = 0;
    logic [7:0]  paddr = 8'h00, grp0 = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [2:0]  pins = 3'h0, mux = 3'h7, dir = 3'h7, pull = 3'h0, pull_o;
    logic [15:0] next_pc, pc_load;
    logic        pready, pslverr, take, valid, wake, ret_irq, pop;
    logic [1:0]  ec [3] = '{2'h3, 2'h0, 2'h2};
    int          err_total = 0, cmp_count = 0, n, k;

    always #20 clock_in = ~clock_in;

    irq_tb_ctrl irq_tb_ctrl_inst (.clock_in(clock_in), .rst_in(rst_in),
        .clk_en_in(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pins_in(pins), .pin_mux_irq_in(mux),
        .pin_dir_input_in(dir), .pin_pull_high_in(pull),
        .pin_pull_high_out(pull_o), .cmp_output_in(cmp_in),
        .conv_done_in(conv_in), .grp0_event_in(grp0), .grp1_event_in(8'h00),
        .grp2_event_in(2'h0), .subclock_tick_in(1'b0), .next_pc_in(next_pc),
        .ret_irq_in(ret_irq), .sleep_in(sleep), .stack_pop_in(pop),
        .irq_take_out(take), .pc_load_out(pc_load),
        .pc_load_valid_out(valid), .wake_out(wake));

    core_model core_model_inst (.clock_in(clock_in), .rst_in(rst_in),
        .pc_load_in(pc_load), .pc_valid_in(valid), .ret_req_in(ret_req),
        .next_pc_out(next_pc), .ret_irq_out(ret_irq), .stack_pop_out(pop));

    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock_in);
            if (pready === 1'b1) break;
        end
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (i == 16) begin
            err_total++;
            print_verdict();
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    task wait_load(input logic [15:0] exp);
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge clock_in);
            if (valid === 1'b1) break;
        end
        if (i == 20) begin
            err_total++;
            print_verdict();
        end
        check({16'h0, pc_load}, {16'h0, exp});
    endtask

    task count_hi(input int sel);
        n = 0;
        repeat (10) begin
            @(negedge clock_in);
            if ((sel == 0 ? valid : wake) === 1'b1) n++;
        end
    endtask

    task settle();
        repeat (5) @(posedge clock_in);
    endtask

    task do_ret();
        @(posedge clock_in); ret_req <= 1'b1;
        @(posedge clock_in); ret_req <= 1'b0;
    endtask

    task s_regs();
        rd_chk(OFF_PSC0, 32'h0);
        rd_chk(OFF_PSC1, 32'h0);
        apb(1'b1, OFF_PSC0, 32'hff);
        rd_chk(OFF_PSC0, 32'h03);
        apb(1'b1, OFF_PERIOD0, 32'hff);
        rd_chk(OFF_PERIOD0, 32'h87);
        apb(1'b1, 8'h40, 32'hff);
        rd_chk(8'h40, 32'h0);
        @(posedge clock_in); pull <= 3'h5;
        settle();
        check({29'h0, pull_o}, 32'h5);
    endtask

    task s_ext();
        apb(1'b1, OFF_EDGE, {30'h0, EDGE_RISE});
        apb(1'b1, OFF_CTRL0, 32'h02);
        @(posedge clock_in); mux <= 3'h0; pins <= 3'h1;
        settle(); rd_chk(OFF_CTRL0, 32'h02);
        @(posedge clock_in); mux <= 3'h7; pins <= 3'h0;
        settle(); rd_chk(OFF_CTRL0, 32'h02);
        @(posedge clock_in); pins <= 3'h1;
        settle(); rd_chk(OFF_CTRL0, 32'h12);
        count_hi(0); check(n, 0);
        apb(1'b1, OFF_CTRL0, 32'h13);
        wait_load(16'h0004);
        rd_chk(OFF_CTRL0, 32'h02);
        do_ret(); wait_load(16'h0002);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, OFF_EDGE, {30'h0, ec[k]});
            @(posedge clock_in); pins <= {2'h0, ~pins[0]};
            settle(); rd_chk(OFF_CTRL0, (ec[k] != 2'h0) ? 32'h12 : 32'h02);
            apb(1'b1, OFF_CTRL0, 32'h02);
        end
    endtask

    task s_prio();
        apb(1'b1, OFF_CTRL0, 32'h04);
        apb(1'b1, OFF_CTRL1, 32'h04);
        @(posedge clock_in); cmp_in <= 1'b1; conv_in <= 1'b1;
        @(posedge clock_in); conv_in <= 1'b0;
        settle(); rd_chk(OFF_CTRL0, 32'h24);
        rd_chk(OFF_CTRL1, 32'h44);
        apb(1'b1, OFF_CTRL0, 32'h25);
        wait_load(16'h0010);
        rd_chk(OFF_CTRL0, 32'h04);
        do_ret(); wait_load(16'h0004);
        apb(1'b1, OFF_CTRL0, 32'h05);
        wait_load(16'h0020);
        rd_chk(OFF_CTRL1, 32'h04);
    endtask

    task s_group();
        @(posedge clock_in); sleep <= 1'b1; grp0 <= 8'h01;
        @(posedge clock_in); grp0 <= 8'h00;
        count_hi(1); check(n != 0, 1);
        rd_chk(OFF_GROUP0, 32'h10);
        @(posedge clock_in); grp0 <= 8'h01;
        @(posedge clock_in); grp0 <= 8'h00;
        count_hi(1); check(n, 0);
        apb(1'b1, OFF_GROUP0, 32'h01);
        @(posedge clock_in); sleep <= 1'b0; grp0 <= 8'h01;
        @(posedge clock_in); grp0 <= 8'h00;
        settle(); rd_chk(OFF_CTRL0, 32'h44);
        apb(1'b1, OFF_CTRL0, 32'h4d);
        wait_load(16'h0014);
        rd_chk(OFF_CTRL0, 32'h0c);
        rd_chk(OFF_GROUP0, 32'h11);
    endtask

    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        s_regs();
        s_ext();
        s_prio();
        s_group();
        print_verdict();
    end
endmodule // test_mcu_interrupt_and_timebase_ctrl
